// ===== hw/poma_pkg.sv
// Constants and register map of the output macrocell array
`default_nettype none
package poma_pkg;
  localparam int NUM_CELLS = 10;
  localparam int NUM_IN    = 12;
  localparam int NUM_SIG   = NUM_IN + NUM_CELLS;
  localparam int NUM_LIT   = 2 * NUM_SIG;
  localparam int MAX_TERMS = 16;
  localparam int NUM_ROWS  = 132;
  localparam int CLEAR_ROW = 130;
  localparam int SET_ROW   = 131;

  // Logic terms per cell; the output-enable row sits just below them
  localparam int TERM_CNT [NUM_CELLS] = '{8, 10, 12, 14, 16,
                                          16, 14, 12, 10, 8};
  localparam int ROW_BASE [NUM_CELLS] = '{0, 9, 20, 33, 48,
                                          65, 82, 97, 110, 121};

  localparam int ADDR_W   = 12;
  localparam int FUSE_HI_W = NUM_LIT - 32;
  localparam logic [ADDR_W-1:0] FUSE_END     = 12'h420;
  localparam logic [ADDR_W-1:0] CFG_MODE_OFF = 12'h420;
  localparam logic [ADDR_W-1:0] OE_MODE_OFF  = 12'h424;
  localparam logic [ADDR_W-1:0] PRELOAD_OFF  = 12'h428;
  localparam logic [ADDR_W-1:0] QSTAT_OFF    = 12'h42c;
  localparam logic [ADDR_W-1:0] PINSTAT_OFF  = 12'h430;

  // Field positions
  localparam int CFG_LOW_LSB  = 0;
  localparam int CFG_HIGH_LSB = 16;
  localparam int STAT_OE_LSB  = 16;

  // Reset values: every literal connected makes every term false
  localparam logic [NUM_LIT-1:0]     FUSE_RST     = 44'hfff_ffff_ffff;
  localparam logic [NUM_CELLS-1:0]   CFG_LOW_RST  = 10'h000;
  localparam logic [NUM_CELLS-1:0]   CFG_HIGH_RST = 10'h000;
  localparam logic [2*NUM_CELLS-1:0] OE_MODE_RST  = 20'h00000;

  // Output enable choice of a combinatorial cell
  localparam logic [1:0] OE_BY_TERM    = 2'h0;
  localparam logic [1:0] OE_ALWAYS_ON  = 2'h1;
  localparam logic [1:0] OE_ALWAYS_OFF = 2'h2;
endpackage
`default_nettype wire

// ===== hw/poma_sync.sv
// Two-flop synchroniser for pin inputs
`default_nettype none
module poma_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule
`default_nettype wire

// ===== hw/poma_and_array.sv
// Programmable AND array: one product term per fuse row
`default_nettype none
module poma_and_array
  import poma_pkg::*;
(
  input  wire logic [NUM_LIT-1:0]                lits,
  input  wire logic [NUM_ROWS-1:0][NUM_LIT-1:0]  fuse,
  output logic      [NUM_ROWS-1:0]               terms
);
  // A set fuse bit connects that literal; all set gives x & ~x = 0
  for (genvar r = 0; r < NUM_ROWS; r++) begin : g_row
    assign terms[r] = ~|(fuse[r] & ~lits);
  end
endmodule
`default_nettype wire

// ===== hw/poma_top.sv
// Ten output macrocells with fuse array behind an APB slave
// Function
// - ten cells in pairs with 8, 10, 12, 14, 16 logic terms
// - each cell has one more term driving its output enable
// - each cell output selectable true or inverted in both modes
// - shared clear term forces every register to zero at next edge
// - shared set term loads one into every register at next edge unless clear or preload
// - clear and set act on Q, registered pin level then follows polarity
// - two config bits per cell pick mode and polarity
// - registered cell pin comes from flip-flop Q through polarity
// - registered cell enable comes from its own enable term
// - registered cell feeds inverted Q back, both polarities
// - registered cell pin never enters the array
// - combinatorial cell pin comes from sum term through polarity
// - combinatorial enable is always on, always off or term driven
// - combinatorial feedback taken from the pin side
// - registers cleared at power-up, preload sets them for test
`default_nettype none
module poma_top
  import poma_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [NUM_IN-1:0]    dataIn,
  input  wire logic [NUM_CELLS-1:0] pinIn,
  output logic      [NUM_CELLS-1:0] pinOut,
  output logic      [NUM_CELLS-1:0] pinOe,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr
);
  logic [NUM_ROWS-1:0][NUM_LIT-1:0] fuse_r;
  logic [NUM_ROWS-1:0][NUM_LIT-1:0] fuse_nxt;
  logic [NUM_CELLS-1:0]   cellCfgBitLow_r;
  logic [NUM_CELLS-1:0]   cellCfgBitLow_nxt;
  logic [NUM_CELLS-1:0]   cellCfgBitHigh_r;
  logic [NUM_CELLS-1:0]   cellCfgBitHigh_nxt;
  logic [2*NUM_CELLS-1:0] oeMode_r;
  logic [2*NUM_CELLS-1:0] oeMode_nxt;
  logic [NUM_CELLS-1:0]   qReg_r;
  logic [NUM_CELLS-1:0]   qReg_nxt;
  logic [NUM_CELLS-1:0]   pinOut_r;
  logic [NUM_CELLS-1:0]   pinOut_nxt;
  logic [NUM_CELLS-1:0]   pinOe_r;
  logic [NUM_CELLS-1:0]   pinOe_nxt;
  logic [31:0]            prdata_r;
  logic [31:0]            prdata_nxt;
  logic                   pready_r;
  logic                   pready_nxt;
  logic                   pslverr_r;
  logic                   pslverr_nxt;

  logic [NUM_SIG-1:0]     syncIn;
  logic [NUM_IN-1:0]      syncData;
  logic [NUM_CELLS-1:0]   syncPin;
  logic [NUM_CELLS-1:0]   fb;
  logic [NUM_SIG-1:0]     sig;
  logic [NUM_LIT-1:0]     lits;
  logic [NUM_ROWS-1:0]    terms;
  logic [NUM_ROWS+MAX_TERMS-1:0] termsPad;
  logic [NUM_CELLS-1:0]   sumTerm;
  logic [NUM_CELLS-1:0]   oeTerm;
  logic [NUM_CELLS-1:0]   oeOn;
  logic [NUM_CELLS-1:0]   oeOff;
  logic [NUM_CELLS-1:0]   driveVal;
  logic                   shared_async_clear_term;
  logic                   shared_sync_set_term;
  logic                   setupPh;
  logic                   accessPh;
  logic                   wrAcc;
  logic                   isFuse;
  logic                   mapped;
  logic                   preloadWr;
  logic [8:0]             fuseRow;

  // Pins and inputs come from the board, so synchronise first
  poma_sync #(
    .WIDTH (NUM_SIG)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({pinIn, dataIn}),
    .dout  (syncIn)
  );

  assign syncData = syncIn[NUM_IN-1:0];
  assign syncPin  = syncIn[NUM_SIG-1:NUM_IN];
  assign sig      = {fb, syncData};

  for (genvar k = 0; k < NUM_SIG; k++) begin : g_lit
    assign lits[2*k]   = sig[k];
    assign lits[2*k+1] = ~sig[k];
  end

  poma_and_array u_array (
    .lits  (lits),
    .fuse  (fuse_r),
    .terms (terms)
  );

  assign termsPad = {{MAX_TERMS{1'b0}}, terms};
  assign shared_async_clear_term = terms[CLEAR_ROW];
  assign shared_sync_set_term    = terms[SET_ROW];

  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    localparam logic [MAX_TERMS-1:0] CNT_MASK =
      MAX_TERMS'((32'h1 << TERM_CNT[c]) - 32'h1);
    logic [1:0] oeSel;
    assign oeSel = oeMode_r[2*c +: 2];
    // Only this cell's share of term rows reaches its OR gate
    assign sumTerm[c] =
      |(termsPad[ROW_BASE[c]+1 +: MAX_TERMS] & CNT_MASK);
    assign oeTerm[c] = terms[ROW_BASE[c]];
    assign oeOn[c]   = oeSel == OE_ALWAYS_ON;
    assign oeOff[c]  = oeSel == OE_ALWAYS_OFF;
    // High bit selects combinatorial; low bit set means active high
    assign driveVal[c] = cellCfgBitHigh_r[c] ? sumTerm[c]
                                             : qReg_nxt[c];
    assign pinOut_nxt[c] = driveVal[c] ^ ~cellCfgBitLow_r[c];
    always_comb begin
      if (!cellCfgBitHigh_r[c]) begin
        pinOe_nxt[c] = oeTerm[c];
      end else if (oeOn[c]) begin
        pinOe_nxt[c] = 1'b1;
      end else if (oeOff[c]) begin
        pinOe_nxt[c] = 1'b0;
      end else begin
        pinOe_nxt[c] = oeTerm[c];
      end
    end
    // Registered pins never feed back, so no dynamic I/O there
    always_comb begin
      if (cellCfgBitHigh_r[c]) begin
        fb[c] = pinOe_r[c] ? pinOut_r[c] : syncPin[c];
      end else begin
        fb[c] = ~qReg_r[c];
      end
    end
  end

  // Register state; clear beats preload, preload beats set
  always_comb begin
    if (shared_async_clear_term) begin
      qReg_nxt = '0;
    end else if (preloadWr) begin
      qReg_nxt = pwdata[NUM_CELLS-1:0];
    end else if (shared_sync_set_term) begin
      qReg_nxt = '1;
    end else begin
      qReg_nxt = sumTerm;
    end
  end

  // Registered cells' pin flops take Q's next value so pin and Q move together
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      qReg_r   <= '0;
      pinOut_r <= '0;
      pinOe_r  <= '0;
    end else begin
      qReg_r   <= qReg_nxt;
      pinOut_r <= pinOut_nxt;
      pinOe_r  <= pinOe_nxt;
    end
  end

  // APB slave, one wait-free access phase after each setup
  assign setupPh   = psel & ~penable;
  assign accessPh  = psel & penable & pready_r;
  assign wrAcc     = accessPh & pwrite & ~pslverr_r;
  assign isFuse    = paddr < FUSE_END;
  assign fuseRow   = paddr[11:3];
  assign mapped    = isFuse | (paddr == CFG_MODE_OFF)
                   | (paddr == OE_MODE_OFF) | (paddr == PRELOAD_OFF)
                   | (paddr == QSTAT_OFF) | (paddr == PINSTAT_OFF);
  assign preloadWr = wrAcc & (paddr == PRELOAD_OFF);

  always_comb begin
    pready_nxt  = setupPh;
    pslverr_nxt = setupPh & ~mapped;
    prdata_nxt  = '0;
    if (setupPh && isFuse) begin
      if (paddr[2]) begin
        prdata_nxt = {{(32-FUSE_HI_W){1'b0}},
                      fuse_r[fuseRow][NUM_LIT-1:32]};
      end else begin
        prdata_nxt = fuse_r[fuseRow][31:0];
      end
    end else if (setupPh) begin
      unique case (paddr)
        CFG_MODE_OFF: begin
          prdata_nxt[CFG_LOW_LSB +: NUM_CELLS]  = cellCfgBitLow_r;
          prdata_nxt[CFG_HIGH_LSB +: NUM_CELLS] = cellCfgBitHigh_r;
        end
        OE_MODE_OFF: begin
          prdata_nxt[2*NUM_CELLS-1:0] = oeMode_r;
        end
        PRELOAD_OFF, QSTAT_OFF: begin
          prdata_nxt[NUM_CELLS-1:0] = qReg_r;
        end
        PINSTAT_OFF: begin
          prdata_nxt[NUM_CELLS-1:0] = pinOut_r;
          prdata_nxt[STAT_OE_LSB +: NUM_CELLS] = pinOe_r;
        end
        default: begin
          prdata_nxt = '0;
        end
      endcase
    end
  end

  // Writes land at the access edge only
  always_comb begin
    fuse_nxt           = fuse_r;
    cellCfgBitLow_nxt  = cellCfgBitLow_r;
    cellCfgBitHigh_nxt = cellCfgBitHigh_r;
    oeMode_nxt         = oeMode_r;
    if (wrAcc && isFuse) begin
      if (paddr[2]) begin
        fuse_nxt[fuseRow][NUM_LIT-1:32] = pwdata[FUSE_HI_W-1:0];
      end else begin
        fuse_nxt[fuseRow][31:0] = pwdata;
      end
    end else if (wrAcc && paddr == CFG_MODE_OFF) begin
      cellCfgBitLow_nxt  = pwdata[CFG_LOW_LSB +: NUM_CELLS];
      cellCfgBitHigh_nxt = pwdata[CFG_HIGH_LSB +: NUM_CELLS];
    end else if (wrAcc && paddr == OE_MODE_OFF) begin
      oeMode_nxt = pwdata[2*NUM_CELLS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fuse_r           <= {NUM_ROWS{FUSE_RST}};
      cellCfgBitLow_r  <= CFG_LOW_RST;
      cellCfgBitHigh_r <= CFG_HIGH_RST;
      oeMode_r         <= OE_MODE_RST;
      prdata_r         <= '0;
      pready_r         <= 1'b0;
      pslverr_r        <= 1'b0;
    end else begin
      fuse_r           <= fuse_nxt;
      cellCfgBitLow_r  <= cellCfgBitLow_nxt;
      cellCfgBitHigh_r <= cellCfgBitHigh_nxt;
      oeMode_r         <= oeMode_nxt;
      prdata_r         <= prdata_nxt;
      pready_r         <= pready_nxt;
      pslverr_r        <= pslverr_nxt;
    end
  end

  assign pinOut  = pinOut_r;
  assign pinOe   = pinOe_r;
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  clear_term_a: assert property (
    shared_async_clear_term |=> qReg_r == '0)
    else $error("clear term did not zero registers");

  set_term_a: assert property (
    shared_sync_set_term && !shared_async_clear_term && !preloadWr
    |=> qReg_r == '1)
    else $error("set term did not load ones");

  clear_pol_a: assert property (
    shared_async_clear_term
    |=> ((pinOut_r ^ ~$past(cellCfgBitLow_r))
         & ~$past(cellCfgBitHigh_r)) == '0)
    else $error("pin after clear ignores polarity");

  reg_pin_a: assert property (
    $past(rst_b) |->
    ((pinOut_r ^ qReg_r ^ ~$past(cellCfgBitLow_r))
     & ~$past(cellCfgBitHigh_r)) == '0)
    else $error("registered pin not Q through polarity");

  reg_oe_a: assert property (
    ((pinOe_r ^ $past(oeTerm)) & ~$past(cellCfgBitHigh_r)) == '0)
    else $error("registered enable not from its term");

  reg_fb_a: assert property (
    ((fb ^ ~qReg_r) & ~cellCfgBitHigh_r) == '0)
    else $error("registered feedback not inverted Q");

  comb_pin_a: assert property (
    ((pinOut_r ^ $past(sumTerm) ^ ~$past(cellCfgBitLow_r))
     & $past(cellCfgBitHigh_r)) == '0)
    else $error("combinatorial pin not sum through polarity");

  comb_oe_a: assert property (
    ((pinOe_r & $past(oeOff & cellCfgBitHigh_r)) == '0)
    && ((~pinOe_r & $past(oeOn & cellCfgBitHigh_r)) == '0))
    else $error("fixed enable choice not obeyed");

  comb_fb_a: assert property (
    ((fb ^ ((pinOe_r & pinOut_r) | (~pinOe_r & syncPin)))
     & cellCfgBitHigh_r) == '0)
    else $error("combinatorial feedback not from pin side");

  preload_a: assert property (
    preloadWr && !shared_async_clear_term
    |=> qReg_r == $past(pwdata[NUM_CELLS-1:0]))
    else $error("preload value not loaded");

  capture_a: assert property (
    !shared_async_clear_term && !shared_sync_set_term && !preloadWr
    |=> qReg_r == $past(sumTerm))
    else $error("register missed sum term");

  apb_ready_a: assert property (
    setupPh |=> pready_r ##1 !pready_r)
    else $error("pready not one cycle after setup");

  clear_seen_c: cover property (shared_async_clear_term);
  set_seen_c: cover property (shared_sync_set_term
                              && !shared_async_clear_term);
  preload_seen_c: cover property (preloadWr);
  dyn_io_c: cover property (cellCfgBitHigh_r[2] && !oeOn[2]
                            && !oeOff[2] && oeTerm[2]);
endmodule
`default_nettype wire

// ===== verif/poma_board.sv
// Board model: cell pins with pull-ups and one external driver
`default_nettype none
module poma_board
  import poma_pkg::*;
(
  input  wire logic [NUM_CELLS-1:0] pinOut,
  input  wire logic [NUM_CELLS-1:0] pinOe,
  input  wire logic [NUM_CELLS-1:0] extDrv,
  input  wire logic [NUM_CELLS-1:0] extEn,
  output logic      [NUM_CELLS-1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ns;

  // Cell wins a contention; the bench never drives an enabled pin
  always_comb begin
    for (int i = 0; i < NUM_CELLS; i++) begin
      if (pinOe[i]) begin
        pinIn[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinIn[i] = extDrv[i];
      end else begin
        pinIn[i] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/poma_top_tb.sv
// Self-checking bench for the output macrocell array
`default_nettype none
module poma_top_tb
  import poma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clk     = 1'b0;
  logic                 rst_b   = 1'b0;
  logic [NUM_IN-1:0]    dataIn  = '0;
  logic [NUM_CELLS-1:0] extDrv  = '0;
  logic [NUM_CELLS-1:0] extEn   = '0;
  logic [NUM_CELLS-1:0] pinIn;
  logic [NUM_CELLS-1:0] pinOut;
  logic [NUM_CELLS-1:0] pinOe;
  logic                 psel    = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite  = 1'b0;
  logic [ADDR_W-1:0]    paddr   = '0;
  logic [31:0]          pwdata  = '0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  int                   err_total = 0;
  int                   compares  = 0;
  int                   cycles    = 0;

  poma_top u_dut (
    .clk(clk), .rst_b(rst_b), .dataIn(dataIn), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  poma_board u_board (
    .pinOut(pinOut), .pinOe(pinOe), .extDrv(extDrv), .extEn(extEn),
    .pinIn(pinIn)
  );

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Outputs are read right after the edge, before flops update
  task automatic apb(input logic isWr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= isWr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask

  task automatic fuse(input int row, input logic [NUM_LIT-1:0] v);
    wr(ADDR_W'(8 * row), v[31:0]);
    wr(ADDR_W'(8 * row + 4), 32'(v[NUM_LIT-1:32]));
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  initial begin
    logic [31:0]        r;
    logic               e;
    logic [NUM_LIT-1:0] v;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    chk(32'(pinOut), 32'h3ff);
    chk(32'(pinOe), 32'h0);
    rd(CFG_MODE_OFF, 32'h0);
    rd(OE_MODE_OFF, 32'h0);
    apb(1'b0, 12'hffc, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    // Last logic row of each cell holds Q through the inverted feedback
    for (int c = 0; c < NUM_CELLS; c++) begin
      v = NUM_LIT'(1) << (2 * (NUM_IN + c) + 1);
      fuse(ROW_BASE[c] + TERM_CNT[c], v);
    end
    fuse(ROW_BASE[3], '0);
    settle();
    chk(32'(pinOe), 32'h8);
    wr(PRELOAD_OFF, 32'h2a5);
    settle();
    rd(QSTAT_OFF, 32'h2a5);
    chk(32'(pinOut), 32'h15a);
    wr(CFG_MODE_OFF, 32'h3ff);
    settle();
    chk(32'(pinOut), 32'h2a5);
    fuse(SET_ROW, '0);
    fuse(SET_ROW, FUSE_RST);
    rd(QSTAT_OFF, 32'h3ff);
    // Clear and set both true: clear must win
    fuse(CLEAR_ROW, '0);
    fuse(SET_ROW, '0);
    rd(QSTAT_OFF, 32'h0);
    chk(32'(pinOut), 32'h0);
    fuse(SET_ROW, FUSE_RST);
    fuse(CLEAR_ROW, FUSE_RST);
    // Cells 0..2 combinatorial: on, off, by term (code 3)
    wr(OE_MODE_OFF, 32'h39);
    rd(OE_MODE_OFF, 32'h39);
    fuse(ROW_BASE[0] + TERM_CNT[0], 44'h1);
    fuse(ROW_BASE[2], '0);
    fuse(ROW_BASE[2] + TERM_CNT[2], 44'h1 << 26);
    wr(CFG_MODE_OFF, 32'h0007_03ff);
    // Pin 4 pulled low outside; registered cell 4 must ignore it
    extEn <= 10'h012;
    for (int k = 0; k < 2; k++) begin
      dataIn <= 12'(k);
      extDrv <= 10'(k << 1);
      settle();
      chk(32'(pinOe), 32'hd);
      chk(32'(pinOut), (k == 1) ? 32'h5 : 32'h2);
    end
    wr(OE_MODE_OFF, 32'h9);
    wr(CFG_MODE_OFF, 32'h0007_03fe);
    settle();
    chk(32'(pinOut), 32'h4);
    chk(32'(pinOe), 32'hd);
    rd(PINSTAT_OFF, 32'h000d_0004);
    rd(ADDR_W'(8 * CLEAR_ROW + 4), 32'hfff);
    end_of_test();
  end
endmodule
`default_nettype wire
